// >>> core_flags_and_dual_pointer.sv
// Top: flag datapath and dual data pointer behind an APB slave.
// Assumes a 100 MHz CORE_CLK, synchronous active-low RESETN and a
// well-behaved APB master; every access is answered in one access cycle.
`timescale 1ns/100ps
`default_nettype none
module core_flags_and_dual_pointer
    import core_flags_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RESETN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             BRANCH_TAKEN
);
    logic [7:0]  acc;
    logic [7:0]  next_acc;
    logic [7:0]  b_reg;
    logic [7:0]  next_b_reg;
    logic [7:0]  cmp_src;
    logic [7:0]  next_cmp_src;
    logic [7:0]  ptr_ctrl;
    logic [7:0]  next_ptr_ctrl;
    logic        carry;
    logic        next_carry;
    logic        aux_carry;
    logic        next_aux_carry;
    logic        overflow;
    logic        next_overflow;
    logic        branch_taken;
    logic        next_branch_taken;
    op_e         last_op;
    op_e         next_last_op;
    logic        ready;
    logic        next_ready;
    logic        slverr;
    logic        next_slverr;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic        setup;
    logic        wr_now;
    logic        mapped;
    logic [7:0]  rd_val;
    op_e         op_in;
    logic        op_ok;
    logic        exec;
    logic        is_move;
    logic        ptr_move;
    logic        sel;
    logic [15:0] main_ptr;
    logic [15:0] shadow_ptr;
    logic [15:0] active_ptr;
    alu_res_s    alu_res;

    // the command decode is shared by the bus check and the execute path
    function automatic logic cmd_valid(input logic [3:0] code);
        return (code != 4'h0) && (code < OP_COUNT);
    endfunction

    assign sel = ptr_ctrl[SELECT_BIT];
    assign active_ptr = sel ? shadow_ptr : main_ptr;
    assign op_in = op_e'(PWDATA[3:0]);
    assign op_ok = cmd_valid(PWDATA[3:0]);
    assign setup = PSEL && !PENABLE;
    // slverr is decided in setup, so a refused write never lands
    assign wr_now = PSEL && PENABLE && ready && PWRITE && !slverr;
    assign exec = wr_now && (PADDR == CMD_ADDR) && op_ok;
    assign is_move = (op_in == OP_CODE_MOVE_PTR) || (op_in == OP_EXT_MOVE_PTR) ||
                     (op_in == OP_CODE_MOVE_OTHER) || (op_in == OP_EXT_MOVE_OTHER);
    assign ptr_move = (op_in == OP_CODE_MOVE_PTR) || (op_in == OP_EXT_MOVE_PTR);

    flag_alu u_alu (
        .op        (op_in),
        .acc       (acc),
        .b         (b_reg),
        .cmp_src   (cmp_src),
        .carry     (carry),
        .aux_carry (aux_carry),
        .overflow  (overflow),
        .res       (alu_res)
    );

    dual_pointer_bank u_ptrs (
        .clk         (CORE_CLK),
        .resetn      (RESETN),
        .sel         (sel),
        .wr_lo       (wr_now && (PADDR == PTR_LO_ADDR)),
        .wr_hi       (wr_now && (PADDR == PTR_HI_ADDR)),
        .wdata       (PWDATA[7:0]),
        .step        (exec && ptr_move),
        .main_mode   (ptr_mode_e'(ptr_ctrl[MAIN_MODE_LSB +: 2])),
        .shadow_mode (ptr_mode_e'(ptr_ctrl[SHADOW_MODE_LSB +: 2])),
        .main_ptr    (main_ptr),
        .shadow_ptr  (shadow_ptr)
    );

    // read mux and address decode
    always_comb
    begin
        rd_val = 8'h00;
        mapped = 1'b1;
        if (PADDR == ACC_ADDR)
            rd_val = acc;
        else if (PADDR == B_ADDR)
            rd_val = b_reg;
        else if (PADDR == FLAGS_ADDR)
        begin
            rd_val[CARRY_BIT] = carry;
            rd_val[AUX_CARRY_BIT] = aux_carry;
            rd_val[OVERFLOW_BIT] = overflow;
        end
        else if (PADDR == CMD_ADDR)
        begin
            rd_val = {4'h0, last_op};
            mapped = !PWRITE || cmd_valid(PWDATA[3:0]);
        end
        else if (PADDR == PTR_LO_ADDR)
            rd_val = active_ptr[7:0];
        else if (PADDR == PTR_HI_ADDR)
            rd_val = active_ptr[15:8];
        else if (PADDR == CMP_SRC_ADDR)
            rd_val = cmp_src;
        else if (PADDR == STATUS_ADDR)
        begin
            rd_val[STAT_TAKEN_BIT] = branch_taken;
            rd_val[STAT_SELECT_BIT] = sel;
        end
        else if (PADDR == PTR_CTRL_ADDR)
            rd_val = ptr_ctrl;
        else
            mapped = 1'b0;
    end

    // bus answer: pready rises for exactly the first access cycle
    always_comb
    begin
        next_ready = setup;
        next_slverr = setup && !mapped;
        next_rdata = 32'h0000_0000;
        if (setup && mapped && !PWRITE)
            next_rdata = {24'h00_0000, rd_val};
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
        begin
            ready <= 1'b0;
            slverr <= 1'b0;
            rdata <= 32'h0000_0000;
        end
        else
        begin
            ready <= next_ready;
            slverr <= next_slverr;
            rdata <= next_rdata;
        end
    end

    // register file and execute
    always_comb
    begin
        next_acc = acc;
        next_b_reg = b_reg;
        next_cmp_src = cmp_src;
        next_ptr_ctrl = ptr_ctrl;
        next_carry = carry;
        next_aux_carry = aux_carry;
        next_overflow = overflow;
        next_branch_taken = branch_taken;
        next_last_op = last_op;
        if (exec)
        begin
            next_last_op = op_in;
            next_acc = alu_res.acc;
            next_b_reg = alu_res.b;
            next_carry = alu_res.carry;
            next_overflow = alu_res.overflow;
            if (op_in == OP_CMP_JUMP)
                next_branch_taken = alu_res.taken;
            // the bank steps the pointer that sel names now; sel flips after
            if (is_move && ptr_ctrl[AUTO_TOGGLE_BIT])
                next_ptr_ctrl[SELECT_BIT] = ~ptr_ctrl[SELECT_BIT];
        end
        else if (wr_now)
        begin
            if (PADDR == ACC_ADDR)
                next_acc = PWDATA[7:0];
            else if (PADDR == B_ADDR)
                next_b_reg = PWDATA[7:0];
            else if (PADDR == CMP_SRC_ADDR)
                next_cmp_src = PWDATA[7:0];
            else if (PADDR == FLAGS_ADDR)
            begin
                next_carry = PWDATA[CARRY_BIT];
                next_aux_carry = PWDATA[AUX_CARRY_BIT];
                next_overflow = PWDATA[OVERFLOW_BIT];
            end
            else if (PADDR == PTR_CTRL_ADDR)
                next_ptr_ctrl = PWDATA[7:0] & PTR_CTRL_MASK;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
        begin
            acc <= REG_RESET;
            b_reg <= REG_RESET;
            cmp_src <= REG_RESET;
            ptr_ctrl <= PTR_CTRL_RESET;
            carry <= 1'b0;
            aux_carry <= 1'b0;
            overflow <= 1'b0;
            branch_taken <= 1'b0;
            last_op <= OP_NONE;
        end
        else
        begin
            acc <= next_acc;
            b_reg <= next_b_reg;
            cmp_src <= next_cmp_src;
            ptr_ctrl <= next_ptr_ctrl;
            carry <= next_carry;
            aux_carry <= next_aux_carry;
            overflow <= next_overflow;
            branch_taken <= next_branch_taken;
            last_op <= next_last_op;
        end
    end

    assign PRDATA = rdata;
    assign PREADY = ready;
    assign PSLVERR = slverr;
    assign BRANCH_TAKEN = branch_taken;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESETN);

    AST_MUL_FLAGS: assert property (
        exec && (op_in == OP_MUL) |=> !carry && (overflow == (b_reg != 8'h00)))
        else $error("multiply flags wrong");

    AST_MUL_PRODUCT: assert property (
        exec && (op_in == OP_MUL) |=> {b_reg, acc} == ({8'h00, $past(acc)} * {8'h00, $past(b_reg)}))
        else $error("multiply product wrong");

    AST_DIV_RESULT: assert property (
        exec && (op_in == OP_DIV) && (b_reg != 8'h00)
        |=> (acc == $past(acc) / $past(b_reg)) && (b_reg == $past(acc) % $past(b_reg)))
        else $error("divide result wrong");

    AST_DIV_FLAGS: assert property (
        exec && (op_in == OP_DIV) |=> !carry && (overflow == ($past(b_reg) == 8'h00)))
        else $error("divide flags wrong");

    AST_DA_LOW_ADJ: assert property (
        exec && (op_in == OP_DA) && !carry && (acc < 8'h90) && (aux_carry || (acc[3:0] > 4'h9))
        |=> acc == 8'($past(acc) + 8'h66))
        else $error("decimal adjust low step wrong");

    AST_DA_HIGH_ADJ: assert property (
        exec && (op_in == OP_DA) && carry && !aux_carry && (acc[3:0] <= 4'h9)
        |=> acc == 8'($past(acc) + 8'h60))
        else $error("decimal adjust high step wrong");

    AST_DA_CARRY: assert property (
        exec && (op_in == OP_DA) && !carry && !aux_carry && (acc[3:0] <= 4'h9)
        |=> (acc == $past(acc)) && (carry == ($past(acc) > 8'h99)))
        else $error("decimal adjust carry wrong");

    AST_RRC: assert property (
        exec && (op_in == OP_RRC) |=> (carry == $past(acc[0])) && (acc == {$past(carry), $past(acc[7:1])}))
        else $error("rotate right wrong");

    AST_RLC: assert property (
        exec && (op_in == OP_RLC) |=> (carry == $past(acc[7])) && (acc == {$past(acc[6:0]), $past(carry)}))
        else $error("rotate left wrong");

    AST_CMP_JUMP: assert property (
        exec && (op_in == OP_CMP_JUMP) |=> BRANCH_TAKEN == ($past(acc) != $past(cmp_src)))
        else $error("compare branch wrong");

    AST_CMP_CARRY: assert property (
        exec && (op_in == OP_CMP_JUMP) |=> carry == ($past(cmp_src) > $past(acc)))
        else $error("compare carry wrong");

    AST_TOGGLE: assert property (
        exec && is_move |=> sel == ($past(sel) ^ $past(ptr_ctrl[AUTO_TOGGLE_BIT])))
        else $error("auto toggle wrong");

    AST_NO_STEP_OTHER: assert property (
        exec && is_move && !ptr_move |=> $stable(main_ptr) && $stable(shadow_ptr))
        else $error("non pointer move changed a pointer");

    AST_MAIN_INC: assert property (
        exec && ptr_move && !sel && (ptr_ctrl[MAIN_MODE_LSB +: 2] == 2'b01)
        |=> (main_ptr == 16'($past(main_ptr) + 16'h0001)) && $stable(shadow_ptr))
        else $error("main increment wrong");

    AST_SHADOW_INC: assert property (
        exec && ptr_move && sel && (ptr_ctrl[SHADOW_MODE_LSB +: 2] == 2'b01)
        |=> (shadow_ptr == 16'($past(shadow_ptr) + 16'h0001)) && $stable(main_ptr))
        else $error("shadow increment wrong");

    AST_MODE_NONE: assert property (
        exec && ptr_move && ((sel ? ptr_ctrl[SHADOW_MODE_LSB +: 2] : ptr_ctrl[MAIN_MODE_LSB +: 2]) == 2'b00)
        |=> $stable(main_ptr) && $stable(shadow_ptr))
        else $error("mode none moved a pointer");

    AST_PTR_VIEW: assert property (
        setup && !PWRITE && (PADDR == PTR_LO_ADDR) |=> PRDATA == {24'h00_0000, $past(active_ptr[7:0])})
        else $error("pointer byte view wrong");

    AST_SHADOW_DEC: assert property (
        exec && ptr_move && sel && (ptr_ctrl[SHADOW_MODE_LSB +: 2] == 2'b10)
        |=> shadow_ptr == 16'($past(shadow_ptr) - 16'h0001))
        else $error("shadow decrement wrong");

    AST_SHADOW_LSB: assert property (
        exec && ptr_move && sel && (ptr_ctrl[SHADOW_MODE_LSB +: 2] == 2'b11)
        |=> shadow_ptr == {$past(shadow_ptr[15:1]), ~$past(shadow_ptr[0])})
        else $error("shadow lsb toggle wrong");

    AST_BIT7_ZERO: assert property (
        wr_now && (PADDR == PTR_CTRL_ADDR) |=> !ptr_ctrl[7] && (ptr_ctrl[6] == $past(PWDATA[6])))
        else $error("control bit 7 took a write");

    AST_ONE_CYCLE_ACCESS: assert property (
        setup |=> PREADY ##1 !PREADY)
        else $error("bus answer not one cycle");

    COV_MUL_OVERFLOW: cover property (exec && (op_in == OP_MUL) ##1 overflow);
    COV_DIV_ZERO: cover property (exec && (op_in == OP_DIV) && (b_reg == 8'h00));
    COV_TOGGLE_MOVE: cover property (exec && ptr_move && ptr_ctrl[AUTO_TOGGLE_BIT] ##1 sel);
    COV_CMP_TAKEN: cover property (exec && (op_in == OP_CMP_JUMP) ##1 BRANCH_TAKEN);
    COV_BAD_CMD: cover property (setup && PWRITE && (PADDR == CMD_ADDR) && !op_ok);
endmodule
`default_nettype wire

// >>> core_flags_pkg.sv
// Package: register map, field layout, op codes and helpers for the flag
// datapath and the dual data pointer.
// Assumes one 100 MHz core clock and register access over 32-bit APB.
`default_nettype none
package core_flags_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0]  ACC_IDX         = 8'h00;
    localparam logic [7:0]  B_IDX           = 8'h01;
    localparam logic [7:0]  FLAGS_IDX       = 8'h02;
    localparam logic [7:0]  CMD_IDX         = 8'h03;
    localparam logic [7:0]  PTR_LO_IDX      = 8'h04;
    localparam logic [7:0]  PTR_HI_IDX      = 8'h05;
    localparam logic [7:0]  CMP_SRC_IDX     = 8'h06;
    localparam logic [7:0]  STATUS_IDX      = 8'h07;
    localparam logic [7:0]  PTR_CTRL_IDX    = 8'hA7;
    localparam logic [11:0] ACC_ADDR        = {2'b00, ACC_IDX, 2'b00};
    localparam logic [11:0] B_ADDR          = {2'b00, B_IDX, 2'b00};
    localparam logic [11:0] FLAGS_ADDR      = {2'b00, FLAGS_IDX, 2'b00};
    localparam logic [11:0] CMD_ADDR        = {2'b00, CMD_IDX, 2'b00};
    localparam logic [11:0] PTR_LO_ADDR     = {2'b00, PTR_LO_IDX, 2'b00};
    localparam logic [11:0] PTR_HI_ADDR     = {2'b00, PTR_HI_IDX, 2'b00};
    localparam logic [11:0] CMP_SRC_ADDR    = {2'b00, CMP_SRC_IDX, 2'b00};
    localparam logic [11:0] STATUS_ADDR     = {2'b00, STATUS_IDX, 2'b00};
    localparam logic [11:0] PTR_CTRL_ADDR   = {2'b00, PTR_CTRL_IDX, 2'b00};
    // pointer_control layout; bits 7 and 1 are not implemented
    localparam int          AUTO_TOGGLE_BIT = 6;
    localparam int          SHADOW_MODE_LSB = 4;
    localparam int          MAIN_MODE_LSB   = 2;
    localparam int          SELECT_BIT      = 0;
    localparam logic [7:0]  PTR_CTRL_MASK   = 8'h7D;
    localparam logic [7:0]  PTR_CTRL_RESET  = 8'h00;
    localparam logic [15:0] PTR_RESET       = 16'h0000;
    // flag and status register layout
    localparam int          CARRY_BIT       = 7;
    localparam int          AUX_CARRY_BIT   = 6;
    localparam int          OVERFLOW_BIT    = 2;
    localparam int          STAT_TAKEN_BIT  = 0;
    localparam int          STAT_SELECT_BIT = 1;
    localparam logic [7:0]  REG_RESET       = 8'h00;
    // arithmetic constants
    localparam logic [15:0] MUL_BYTE_MAX    = 16'h00FF;
    localparam logic [3:0]  BCD_DIGIT_MAX   = 4'h9;
    localparam logic [8:0]  DA_LOW_ADJ      = 9'h006;
    localparam logic [8:0]  DA_HIGH_ADJ     = 9'h060;
    localparam logic [8:0]  DA_CARRY_LIMIT  = 9'h099;
    localparam logic [3:0]  OP_COUNT        = 4'hB;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_MUL,
        OP_DIV,
        OP_DA,
        OP_RRC,
        OP_RLC,
        OP_CMP_JUMP,
        OP_CODE_MOVE_PTR,
        OP_EXT_MOVE_PTR,
        OP_CODE_MOVE_OTHER,
        OP_EXT_MOVE_OTHER
    } op_e;

    typedef enum logic [1:0] {
        MODE_NONE,
        MODE_INC,
        MODE_DEC,
        MODE_TOGGLE
    } ptr_mode_e;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] b;
        logic       carry;
        logic       overflow;
        logic       taken;
    } alu_res_s;

    function automatic logic [15:0] ptr_next(input logic [15:0] ptr, input ptr_mode_e mode);
        logic [15:0] r;
        r = ptr;
        case (mode)
            MODE_INC:    r = ptr + 16'h0001;
            MODE_DEC:    r = ptr - 16'h0001;
            MODE_TOGGLE: r = {ptr[15:1], ~ptr[0]};
            default:     r = ptr;
        endcase
        return r;
    endfunction
endpackage
`default_nettype wire

// >>> flag_alu.sv
// Combinational result and flag logic for the multiply, divide, decimal
// adjust, rotate and compare operations.
// Assumes the caller registers the result on its execute pulse.
`timescale 1ns/100ps
`default_nettype none
module flag_alu
    import core_flags_pkg::*;
(
    input  wire op_e        op,
    input  wire logic [7:0] acc,
    input  wire logic [7:0] b,
    input  wire logic [7:0] cmp_src,
    input  wire logic       carry,
    input  wire logic       aux_carry,
    input  wire logic       overflow,
    output alu_res_s        res
);
    always_comb
    begin
        logic [15:0] prod;
        logic [8:0]  da;
        logic        low_fix;
        prod = {8'h00, acc} * {8'h00, b};
        da = {1'b0, acc};
        low_fix = aux_carry || (acc[3:0] > BCD_DIGIT_MAX);
        res = '{acc: acc, b: b, carry: carry, overflow: overflow, taken: 1'b0};
        case (op)
            OP_MUL:
            begin
                res.acc = prod[7:0];
                res.b = prod[15:8];
                res.carry = 1'b0;
                res.overflow = prod > MUL_BYTE_MAX;
            end
            OP_DIV:
            begin
                res.carry = 1'b0;
                res.overflow = (b == 8'h00);
                // zero divisor leaves acc and b as they were
                if (b != 8'h00)
                begin
                    res.acc = acc / b;
                    res.b = acc % b;
                end
            end
            OP_DA:
            begin
                if (low_fix)
                    da = da + DA_LOW_ADJ;
                if (carry || low_fix)
                    da = da + DA_HIGH_ADJ;
                res.acc = da[7:0];
                res.carry = da > DA_CARRY_LIMIT;
            end
            OP_RRC:
            begin
                res.acc = {carry, acc[7:1]};
                res.carry = acc[0];
            end
            OP_RLC:
            begin
                res.acc = {acc[6:0], carry};
                res.carry = acc[7];
            end
            OP_CMP_JUMP:
            begin
                res.taken = (acc != cmp_src);
                res.carry = cmp_src > acc;
            end
            default:
            begin
                res.taken = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// >>> dual_pointer_bank.sv
// Main and shadow 16-bit data pointers with byte writes to the active one
// and a per-pointer post-step on a qualifying move.
// Assumes step and byte writes never arrive in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module dual_pointer_bank
    import core_flags_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        sel,
    input  wire logic        wr_lo,
    input  wire logic        wr_hi,
    input  wire logic [7:0]  wdata,
    input  wire logic        step,
    input  wire ptr_mode_e   main_mode,
    input  wire ptr_mode_e   shadow_mode,
    output logic      [15:0] main_ptr,
    output logic      [15:0] shadow_ptr
);
    logic [15:0] next_main_ptr;
    logic [15:0] next_shadow_ptr;

    always_comb
    begin
        next_main_ptr = main_ptr;
        next_shadow_ptr = shadow_ptr;
        // only the active pointer is touched, by a write or by a step
        if (!sel)
        begin
            if (wr_lo)
                next_main_ptr[7:0] = wdata;
            else if (wr_hi)
                next_main_ptr[15:8] = wdata;
            else if (step)
                next_main_ptr = ptr_next(main_ptr, main_mode);
        end
        else
        begin
            if (wr_lo)
                next_shadow_ptr[7:0] = wdata;
            else if (wr_hi)
                next_shadow_ptr[15:8] = wdata;
            else if (step)
                next_shadow_ptr = ptr_next(shadow_ptr, shadow_mode);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            main_ptr <= PTR_RESET;
            shadow_ptr <= PTR_RESET;
        end
        else
        begin
            main_ptr <= next_main_ptr;
            shadow_ptr <= next_shadow_ptr;
        end
    end
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the flag datapath and the dual data pointer.
// Drives the APB port directly, with no partner model; assertions live in the design.
`timescale 1ns/100ps
`default_nettype none
module tb
    import core_flags_pkg::*;
;
    logic        clk  = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        pen  = 1'b0;
    logic        pwr  = 1'b0;
    logic [11:0] pa   = 12'h000;
    logic [31:0] pwd  = 32'h0000_0000;
    logic [31:0] prd;
    logic        prdy;
    logic        perr;
    logic        taken;
    logic [31:0] seed = 32'h57c6_ce2a;
    int          miscompares = 0;
    int          compares = 0;

    core_flags_and_dual_pointer uut (.CORE_CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .BRANCH_TAKEN(taken));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // expected {acc, b, flags}; flags carry bit 7, aux carry bit 6, overflow bit 2
    function automatic logic [23:0] alu_exp(input int op, input logic [7:0] a, b, s, f);
        logic [15:0] p;
        logic [8:0]  d;
        p = a * b;
        d = {1'b0, a};
        if (f[6] || a[3:0] > 4'h9) d = d + 9'h006;
        if (f[7] || f[6] || a[3:0] > 4'h9) d = d + 9'h060;
        case (op)
            1: return {p[7:0], p[15:8], 1'b0, f[6], 3'b000, p > 16'h00FF, 2'b00};
            2: return (b == 8'h00) ? {a, b, 1'b0, f[6], 3'b000, 1'b1, 2'b00} : {a / b, a % b, 1'b0, f[6], 6'b000000};
            3: return {d[7:0], b, d > 9'h099, f[6], 6'b000000};
            4: return {f[7], a[7:1], b, a[0], f[6], 6'b000000};
            5: return {a[6:0], f[7], b, a[7], f[6], 6'b000000};
            default: return {a, b, s > a, f[6], 6'b000000};
        endcase
    endfunction

    function automatic logic [15:0] step(input logic [15:0] p, input logic [1:0] m);
        return (m == 2'b01) ? p + 16'h0001 : (m == 2'b10) ? p - 16'h0001 : (m == 2'b11) ? p ^ 16'h0001 : p;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // psel stays up between back-to-back transfers so no signal is driven twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r,
        output logic e);
        int n;
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= {24'h00_0000, d};
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        // pready and read data are taken at the rising edge itself
        do
        begin
            @(posedge clk);
            n++;
        end
        while (prdy !== 1'b1 && n < 16);
        if (prdy !== 1'b1)
        begin
            miscompares++;
            complete_run();
        end
        r = prd;
        e = perr;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 8'h00, r, e);
        check(what, r & m, exp & m);
    endtask

    initial
    begin
        forever #5 clk = ~clk;
    end

    initial
    begin
        logic [7:0]  a, b, s, f;
        logic [23:0] e;
        logic [15:0] pv, mn, sh;
        logic [31:0] r;
        logic        err, sel;
        int          i, op;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rdc("ctrl_reset", PTR_CTRL_ADDR, 32'hFF, 32'h0000_0000);
        rdc("ptr_reset", PTR_LO_ADDR, 32'hFF, 32'h0000_0000);
        apb(1'b0, 12'h020, 8'h00, r, err);
        check("unmapped_err", 32'(err), 32'h0000_0001);
        for (i = 0; i < 120; i++)
        begin
            op = 1 + i % 6;
            a = 8'(rnd());
            b = (i == 7) ? 8'h00 : 8'(rnd());
            s = (i % 12 == 11) ? a : 8'(rnd());
            f = 8'(rnd()) & 8'hC4;
            wr(ACC_ADDR, a);
            wr(B_ADDR, b);
            wr(CMP_SRC_ADDR, s);
            wr(FLAGS_ADDR, f);
            wr(CMD_ADDR, 8'(op));
            rdc("last_op", CMD_ADDR, 32'hFF, 32'(op));
            e = alu_exp(op, a, b, s, f);
            // divide by zero leaves acc and b unchanged; their reads are masked out here
            rdc("acc", ACC_ADDR, (op == 2 && b == 8'h00) ? 0 : 32'hFF, 32'(e[23:16]));
            rdc("b", B_ADDR, (op == 2 && b == 8'h00) ? 0 : 32'hFF, 32'(e[15:8]));
            rdc("flags", FLAGS_ADDR, (op < 3) ? 32'hC4 : 32'hC0, 32'(e[7:0]));
            if (op == 6)
                check("branch", 32'(taken), 32'(s != a));
        end
        // codes 11 to 15 and 0 are refused and leave the last op in place
        for (i = 11; i < 17; i++)
        begin
            apb(1'b1, CMD_ADDR, 8'(i % 16), r, err);
            check("bad_cmd_err", 32'(err), 32'h0000_0001);
        end
        rdc("last_op_kept", CMD_ADDR, 32'hFF, 32'(op));
        apb(1'b0, 12'h001, 8'h00, r, err);
        check("misaligned_err", 32'(err), 32'h0000_0001);
        mn = 16'h0000;
        sh = 16'h0000;
        for (i = 0; i < 48; i++)
        begin
            f = 8'(rnd());
            wr(PTR_CTRL_ADDR, f);
            rdc("ctrl", PTR_CTRL_ADDR, 32'hFF, 32'(f & 8'h7D));
            sel = f[0];
            pv = (i % 8 == 0) ? 16'hFFFF : (i % 8 == 1) ? 16'h0000 : 16'(rnd());
            wr(PTR_LO_ADDR, pv[7:0]);
            wr(PTR_HI_ADDR, pv[15:8]);
            if (sel) sh = pv;
            else mn = pv;
            op = 7 + i % 4;
            wr(CMD_ADDR, 8'(op));
            if (op < 9 && sel) sh = step(sh, f[5:4]);
            if (op < 9 && !sel) mn = step(mn, f[3:2]);
            sel = sel ^ f[6];
            pv = sel ? sh : mn;
            rdc("ptr_lo", PTR_LO_ADDR, 32'hFF, 32'(pv[7:0]));
            rdc("ptr_hi", PTR_HI_ADDR, 32'hFF, 32'(pv[15:8]));
            rdc("select", STATUS_ADDR, 32'h2, {30'h0000_0000, sel, 1'b0});
        end
        // second reset in mid-run must bring control and pointers back to zero
        psel <= 1'b0;
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rdc("ctrl_rerun", PTR_CTRL_ADDR, 32'hFF, 32'h0000_0000);
        rdc("ptr_rerun", PTR_HI_ADDR, 32'hFF, 32'h0000_0000);
        psel <= 1'b0;
        @(posedge clk);
        complete_run();
    end
endmodule
`default_nettype wire
